// file: logic/interval_timer.sv
/*
  14-bit interval timer with buzzer and a small apb slave.
  holds:
  - an 8-bit up-counter cascaded into a 6-bit up-counter, with a
    fast mode that clocks the 6-bit stage straight from the count clock
  - a count clock selector over subclock, cycle clock and the timer 0
    prescaler output, turned into a one-cycle enable pulse
  - two sticky interrupt flags with programmable periods, one shared
    request output and a hold release output
  - a count clock over 16 buzzer, anded with the timer 1 high pwm level
  - two 8-bit control registers plus a status and a mask word, reached
    over apb with one wait state on every access
  assumes:
  - count clock sources arrive as levels synchronous to CORE_CLK and stay
    high and low for at least one CORE_CLK cycle each
  - COUNTER_CLEAR, HOLD_ACTIVE and HOLD_RUN_EN are synchronous levels
  - the apb master keeps address and data stable until PREADY
  - software clears the spurious flag 1 after rewriting the period bits
*/
`include "bt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module interval_timer
  import bt_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // count clock sources
  input wire logic SUBCLK_IN,
  input wire logic CYCLE_CLK_IN,
  input wire logic PRESC_IN,
  // power and buzzer
  input wire logic HOLD_ACTIVE,
  input wire logic HOLD_RUN_EN,
  input wire logic TIMER1_HIGH_PWM,
  input wire logic COUNTER_CLEAR,
  output logic BUZZER_PORT_PIN,
  output logic IRQ_REQ,
  output logic HOLD_RELEASE,
  output logic IRQ
);
  logic [7:0] tctl_ff;
  logic [7:0] isel_ff;
  logic [1:0] imask_ff;
  logic [7:0] lo_ff;
  logic [5:0] hi_ff;
  logic [3:0] buzdiv_ff;
  logic src_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic buzz_ff;
  logic irq_req_ff;
  logic hold_rel_ff;
  logic irq_ff;
  logic src_lvl;
  logic tick;
  logic running;
  logic lo_ovf;
  logic hi_tick;
  logic hi_ovf;
  logic set0;
  logic set1;
  logic p1_changed;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [1:0] nxt_pend;
  count_src_t src_sel;
  logic isel_hit;
  logic tctl_hit;
  logic stat_hit;
  logic mask_hit;
  logic first_acc;
  logic [7:0] nxt_lo;
  logic [5:0] nxt_hi;
  logic [7:0] nxt_tctl;
  logic nxt_if1;
  logic nxt_if0;
  logic [7:0] nxt_isel;
  logic [1:0] nxt_imask;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic nxt_buzz;
  logic buz_src;

  // address decode helper
  function automatic logic hit(input logic [17:0] a);
    hit = (a == `ISEL_ADDR) || (a == `TCTL_ADDR) ||
          (a == `STAT_ADDR) || (a == `MASK_ADDR);
  endfunction

  assign wr_acc = PSEL && PENABLE && PWRITE && pready_ff;
  assign rd_acc = PSEL && PENABLE && !PWRITE && pready_ff;
  assign wbyte = PWDATA[7:0];

  // register selects, shared by write and read paths
  assign isel_hit = (PADDR == `ISEL_ADDR);
  assign tctl_hit = (PADDR == `TCTL_ADDR);
  assign stat_hit = (PADDR == `STAT_ADDR);
  assign mask_hit = (PADDR == `MASK_ADDR);

  // count clock mux
  assign src_sel = count_src_t'({isel_ff[`SRCHI_BIT], isel_ff[`SRCLO_BIT]});
  always_comb begin
    unique case (src_sel)
      SRC_SUB_A: src_lvl = SUBCLK_IN;
      SRC_CYCLE: src_lvl = CYCLE_CLK_IN;
      SRC_SUB_B: src_lvl = SUBCLK_IN;
      SRC_PRESC: src_lvl = PRESC_IN;
    endcase
  end

  // rising edge of the count clock as enable
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      src_ff <= 1'b0;
    end else begin
      src_ff <= src_lvl;
    end
  end
  assign tick = src_lvl && !src_ff;

  // stop at zero when run bit clear; gated in hold
  assign running = (tctl_ff[`RUN_BIT] || (lo_ff != 8'h00) ||
                    (hi_ff != 6'h00)) &&
                   (!HOLD_ACTIVE || HOLD_RUN_EN);
  assign lo_ovf = tick && running && (lo_ff == 8'hff);
  // fast mode clocks the 6-bit stage straight from the count clock
  assign hi_tick = tctl_ff[`FAST_BIT] ? (tick && running) : lo_ovf;
  assign hi_ovf = hi_tick && (hi_ff == 6'h3f);
  assign set0 = hi_ovf;

  // flag 1 interval select
  always_comb begin
    unique case ({tctl_ff[`FAST_BIT], tctl_ff[`P1HI_BIT], tctl_ff[`P1LO_BIT]})
      3'b000, 3'b100: set1 = tick && running && (lo_ff[4:0] == 5'h1f);
      3'b001, 3'b101: set1 = tick && running && (lo_ff[6:0] == 7'h7f);
      3'b010: set1 = hi_tick && (hi_ff[0] == 1'b1); // 512 counts
      3'b011: set1 = hi_tick && (hi_ff[2:0] == 3'h7); // 2048 counts
      3'b110: set1 = tick && running && (hi_ff[0] == 1'b1);
      3'b111: set1 = tick && running && (hi_ff[2:0] == 3'h7);
    endcase
  end

  // period bits rewrite may raise flag 1
  assign p1_changed = wr_acc && (PADDR == `TCTL_ADDR) &&
    (wbyte[`P1HI_BIT:`P1LO_BIT] != tctl_ff[`P1HI_BIT:`P1LO_BIT]);

  // counter stages: next values
  always_comb begin
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    if (COUNTER_CLEAR) begin
      nxt_lo = 8'h00;
      nxt_hi = 6'h00;
    end else begin
      if (tick && running) begin
        nxt_lo = lo_ff + 8'h01;
      end
      if (hi_tick) begin
        nxt_hi = hi_ff + 6'h01;
      end
    end
  end

  // 8-bit stage
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      lo_ff <= 8'h00;
    end else begin
      lo_ff <= nxt_lo;
    end
  end

  // 6-bit stage
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      hi_ff <= 6'h00;
    end else begin
      hi_ff <= nxt_hi;
    end
  end

  // buzzer divider: one toggle per eight ticks gives count clock / 16
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      buzdiv_ff <= 4'h0;
    end else if (tick) begin
      buzdiv_ff <= buzdiv_ff + 4'h1;
    end
  end

  // flag next values; a set in the same cycle as a clear wins
  always_comb begin
    nxt_if1 = tctl_ff[`IF1_BIT];
    nxt_if0 = tctl_ff[`IF0_BIT];
    if (wr_acc && tctl_hit) begin
      // control write: a zero clears, a one keeps
      nxt_if1 = tctl_ff[`IF1_BIT] && wbyte[`IF1_BIT];
      nxt_if0 = tctl_ff[`IF0_BIT] && wbyte[`IF0_BIT];
    end else if (wr_acc && stat_hit) begin
      // status write: a one clears
      nxt_if1 = tctl_ff[`IF1_BIT] && !PWDATA[1];
      nxt_if0 = tctl_ff[`IF0_BIT] && !PWDATA[0];
    end
    if (set1 || p1_changed) begin
      nxt_if1 = 1'b1;
    end
    if (set0) begin
      nxt_if0 = 1'b1;
    end
  end

  // control register next value
  always_comb begin
    nxt_tctl = tctl_ff;
    if (wr_acc && tctl_hit) begin
      nxt_tctl[7:4] = wbyte[7:4];
      nxt_tctl[`IE1_BIT] = wbyte[`IE1_BIT];
      nxt_tctl[`IE0_BIT] = wbyte[`IE0_BIT];
    end
    nxt_tctl[`IF1_BIT] = nxt_if1;
    nxt_tctl[`IF0_BIT] = nxt_if0;
  end

  // control register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tctl_ff <= `TCTL_RST;
    end else begin
      tctl_ff <= nxt_tctl;
    end
  end

  // input select and mask next values
  always_comb begin
    nxt_isel = isel_ff;
    nxt_imask = imask_ff;
    if (wr_acc && isel_hit) begin
      nxt_isel = wbyte;
    end
    if (wr_acc && mask_hit) begin
      nxt_imask = PWDATA[1:0];
    end
  end

  // input select register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      isel_ff <= `ISEL_RST;
    end else begin
      isel_ff <= nxt_isel;
    end
  end

  // interrupt mask register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      imask_ff <= `IMASK_RST;
    end else begin
      imask_ff <= nxt_imask;
    end
  end

  // apb answer next values: one wait state, then ready for one cycle
  always_comb begin
    first_acc = PSEL && PENABLE && !pready_ff;
    nxt_pready = first_acc;
    nxt_pslverr = first_acc && !hit(PADDR);
    nxt_prdata = 32'h00000000;
    if (first_acc && !PWRITE) begin
      if (isel_hit) begin
        nxt_prdata = {24'h000000, isel_ff};
      end else if (tctl_hit) begin
        nxt_prdata = {24'h000000, tctl_ff};
      end else if (stat_hit) begin
        nxt_prdata = {30'h0, tctl_ff[`IF1_BIT], tctl_ff[`IF0_BIT]};
      end else if (mask_hit) begin
        nxt_prdata = {30'h0, imask_ff};
      end
    end
  end

  // apb answer registers; refused reads return zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // request, wake and interrupt outputs
  assign nxt_pend = {tctl_ff[`IF1_BIT] && tctl_ff[`IE1_BIT],
                     tctl_ff[`IF0_BIT] && tctl_ff[`IE0_BIT]};
  assign buz_src = isel_ff[`BUZ_BIT] ? buzdiv_ff[3] : 1'b1;
  assign nxt_buzz = buz_src && TIMER1_HIGH_PWM;

  // shared interrupt request
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      irq_req_ff <= 1'b0;
    end else begin
      irq_req_ff <= |nxt_pend;
    end
  end

  // hold release follows the same request
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      hold_rel_ff <= 1'b0;
    end else begin
      hold_rel_ff <= |nxt_pend;
    end
  end

  // masked status interrupt
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |({tctl_ff[`IF1_BIT], tctl_ff[`IF0_BIT]} & imask_ff);
    end
  end

  // buzzer pin, idle high
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      buzz_ff <= 1'b1;
    end else begin
      buzz_ff <= nxt_buzz;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign BUZZER_PORT_PIN = buzz_ff;
  assign IRQ_REQ = irq_req_ff;
  assign HOLD_RELEASE = hold_rel_ff;
  assign IRQ = irq_ff;
endmodule
`default_nettype wire

// file: logic/bt_params.svh
/*
  offsets, field positions and reset values for the interval timer.
  assumes it is included by its bare name from the design and bench files.
*/
`ifndef BT_PARAMS_SVH
`define BT_PARAMS_SVH

// register byte addresses (offsets are multiples of four: index * 4)
`define ISEL_INDEX 16'hfe5f
`define TCTL_INDEX 16'hfe7f
`define ISEL_ADDR 18'h3f97c
`define TCTL_ADDR 18'h3f9fc
`define STAT_ADDR 18'h00000
`define MASK_ADDR 18'h00004

// interval_timer_ctrl fields
`define FAST_BIT 7
`define RUN_BIT 6
`define P1HI_BIT 5
`define P1LO_BIT 4
`define IF1_BIT 3
`define IE1_BIT 2
`define IF0_BIT 1
`define IE0_BIT 0

// input_select_ctrl fields
`define SRCHI_BIT 5
`define SRCLO_BIT 4
`define BUZ_BIT 3

// reset values
`define TCTL_RST 8'h00
`define ISEL_RST 8'h00
`define IMASK_RST 2'h0

`endif

// file: logic/bt_pkg.sv
/*
  types shared by the interval timer files.
  assumes the params header sits next to it.
*/
package bt_pkg;
  typedef enum logic [1:0] {
    SRC_SUB_A = 2'b00,
    SRC_CYCLE = 2'b01,
    SRC_SUB_B = 2'b10,
    SRC_PRESC = 2'b11
  } count_src_t;
endpackage

// file: bench/interval_timer_checker.sv
/* port checker for interval_timer.
   assumes it is bound onto the timer top. */
`include "bt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module interval_timer_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // buzzer and requests
  input wire logic TIMER1_HIGH_PWM,
  input wire logic BUZZER_PORT_PIN,
  input wire logic IRQ_REQ,
  input wire logic HOLD_RELEASE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // bus answer timing and refusal
  AST_RDY_ONE: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  AST_RDY_LAT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  AST_ERR_RDY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_ERR_MAP: assert property (PREADY |-> PSLVERR == !(PADDR inside
    {`ISEL_ADDR, `TCTL_ADDR, `STAT_ADDR, `MASK_ADDR}))
    else $error("error flag wrong");
  AST_RD_ZERO: assert property (PREADY && PSLVERR && !PWRITE |->
    PRDATA == 32'h0) else $error("refused read not zero");
  AST_PRD_HI: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  // buzzer gating and wake signal
  AST_BUZ_PWM: assert property (!TIMER1_HIGH_PWM |=> !BUZZER_PORT_PIN)
    else $error("buzzer not gated");
  AST_WAKE_EQ: assert property (HOLD_RELEASE == IRQ_REQ)
    else $error("release differs from request");
  cover property (PREADY && PSLVERR);
  cover property (IRQ_REQ);
  cover property (!BUZZER_PORT_PIN ##1 BUZZER_PORT_PIN);
endmodule
bind interval_timer interval_timer_checker chk (.CORE_CLK(CORE_CLK),
  .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER1_HIGH_PWM(TIMER1_HIGH_PWM), .BUZZER_PORT_PIN(BUZZER_PORT_PIN),
  .IRQ_REQ(IRQ_REQ), .HOLD_RELEASE(HOLD_RELEASE));
`default_nettype wire

// file: bench/interval_timer_test.sv
/* self-checking bench for interval_timer.
   assumes design and checker files compile first. */
`include "bt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module interval_timer_test;
  logic clk, rst_b, psel, pen, pwr, hold, hren, pwm, clr;
  logic prdy, perr, buz, ireq, hrel, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] src;
  logic [1:0] sel;
  int failures, num_checks;
  int per[8] = '{32, 128, 512, 2048, 32, 128, 2, 8};
  interval_timer dut (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr), .SUBCLK_IN(src[0]),
    .CYCLE_CLK_IN(src[1]), .PRESC_IN(src[2]), .HOLD_ACTIVE(hold),
    .HOLD_RUN_EN(hren), .TIMER1_HIGH_PWM(pwm), .COUNTER_CLEAR(clr),
    .BUZZER_PORT_PIN(buz), .IRQ_REQ(ireq), .HOLD_RELEASE(hrel), .IRQ(irq));
  // clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // one apb transfer, read data kept in rd
  task automatic apb(logic w, logic [17:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prdata;
    psel <= 0;
    pen <= 0;
  endtask
  // n rising edges on the selected source line
  task automatic tick(int n);
    repeat (n) begin
      @(posedge clk);
      src[sel == 2'h1 ? 1 : sel == 2'h3 ? 2 : 0] <= 1;
      @(posedge clk);
      src <= 3'h0;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic start(logic [7:0] c);
    @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    apb(1, `TCTL_ADDR, {24'h0, c});
    apb(1, `STAT_ADDR, 32'h3);
  endtask
  task automatic period(logic [7:0] c, int n);
    start(c);
    tick(n - 1);
    cmp("req early", 1'h0, ireq);
    tick(1);
    cmp("req due", 1'h1, ireq);
    apb(1, `STAT_ADDR, 32'h3);
  endtask
  task automatic t_regs;
    apb(0, `TCTL_ADDR, 32'h0);
    cmp("ctrl", 32'h0, rd);
    apb(0, `ISEL_ADDR, 32'h0);
    cmp("isel", 32'h0, rd);
    apb(0, 18'h00100, 32'h0);
    cmp("unmapped", 32'h0, rd);
    cmp("buz off", 1'h1, buz);
  endtask
  task automatic t_buzzer;
    apb(1, `ISEL_ADDR, 32'h8);
    tick(7);
    cmp("buz low", 1'h0, buz);
    tick(1);
    cmp("buz high", 1'h1, buz);
    @(posedge clk);
    pwm <= 0;
    tick(0);
    cmp("buz gated", 1'h0, buz);
    @(posedge clk);
    pwm <= 1;
    apb(1, `ISEL_ADDR, 32'h0);
  endtask
  task automatic t_table;
    for (int i = 0; i < 8; i++) begin
      sel = i[1:0];
      apb(1, `ISEL_ADDR, {26'h0, sel, 4'h0});
      period({i[2], 1'b1, i[1:0], 4'h4}, per[i]);
    end
    apb(0, `ISEL_ADDR, 32'h0);
    cmp("isel back", 32'h30, rd);
    sel = 2'h0;
    apb(1, `ISEL_ADDR, 32'h0);
    period(8'h41, 16384);
  endtask
  task automatic t_irq;
    start(8'hc1);
    tick(64);
    cmp("irq masked", 1'h0, irq);
    cmp("release", 1'h1, hrel);
    apb(1, `MASK_ADDR, 32'h1);
    tick(0);
    cmp("irq", 1'h1, irq);
    apb(1, `STAT_ADDR, 32'h1);
    tick(0);
    cmp("irq clr", 1'h0, irq);
    cmp("req clr", 1'h0, ireq);
    apb(1, `MASK_ADDR, 32'h0);
  endtask
  task automatic t_stop;
    start(8'hc1);
    tick(10);
    cmp("not due", 1'h0, ireq);
    apb(1, `TCTL_ADDR, 32'h81);
    tick(54);
    cmp("run down", 1'h1, ireq);
    tick(192);
    apb(1, `STAT_ADDR, 32'h3);
    tick(64);
    cmp("stopped", 1'h0, ireq);
  endtask
  task automatic t_hold;
    @(posedge clk);
    hold <= 1;
    start(8'hc1);
    tick(64);
    cmp("held", 1'h0, ireq);
    @(posedge clk);
    hren <= 1;
    tick(64);
    cmp("hold run", 1'h1, hrel);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    {psel, pen, pwr, hold, hren, clr, src, sel} = 0;
    {pwm, rst_b, paddr, pwdata, failures, num_checks} = 0;
    pwm = 1;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    t_regs;
    t_buzzer;
    t_table;
    t_irq;
    t_stop;
    t_hold;
    tally_and_finish;
  end
endmodule
`default_nettype wire
